/* core/cts_defines.svh */
`ifndef CTS_DEFINES_SVH
`define CTS_DEFINES_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CTS_NUM_PORTS 28
`define CTS_PORT_BASE_OFS 16'h1000
`define CTS_PORT_STRIDE 16'h0002
`define CTS_BUF_CONFIG_OFS 16'h1038
`define CTS_BUF_WPTR_OFS 16'h103A
`define CTS_BUF_RPTR_OFS 16'h103C
`define CTS_TX_CTRL_OFS 16'h103E
`define CTS_GAP_TIMER_OFS 16'h1040
`define CTS_TX_STATUS_OFS 16'h1042
`define CTS_MASTER_EN_OFS 16'h1044

// ****************************************
// Field positions
// ****************************************
`define CTS_PORT_BASE_MSB 13
`define CTS_PORT_MODE_LSB 14
`define CTS_CAPACITY_MSB 1
`define CTS_BUF_BASE_LSB 2
`define CTS_BUF_BASE_MSB 9
`define CTS_FILL_PTR_MSB 7
`define CTS_FETCH_PTR_MSB 6
`define CTS_EN_BIT 0
`define CTS_AUTO_BIT 1
`define CTS_EMPTY_SE_BIT 2
`define CTS_GAP_MSB 9

// ****************************************
// Reset values and timing
// ****************************************
`define CTS_PORT_RST 16'h0000
`define CTS_BUF_CONFIG_RST 10'h000
`define CTS_BUF_WPTR_RST 8'h00
`define CTS_TX_CTRL_RST 3'h0
`define CTS_GAP_TIMER_RST 10'h001
`define CTS_MASTER_EN_RST 1'h0
`define CTS_GAP_UNIT_CLKS 16'hFFFF

`endif

/* core/cts_pkg.sv */
package cts_pkg;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      CTS_MODE_OFF = 2'h0,
      CTS_MODE_UNSTRUCT = 2'h1,
      CTS_MODE_RSVD = 2'h2,
      CTS_MODE_STRUCT = 2'h3
   } cts_port_mode_t;

   typedef enum logic {
      CTS_TX_IDLE,
      CTS_TX_FETCH
   } cts_tx_state_t;

endpackage : cts_pkg

/* core/cts_dtx_if.sv */
`timescale 1ns/100ps

interface cts_dtx_if;
   logic enable;
   logic auto_mode;
   logic [9:0] gap_period;
   logic [1:0] capacity;
   logic [7:0] fill_ptr;
   logic cbr_idle;
   logic cell_done;
   logic [6:0] fetch_ptr;
   logic cell_req;
   logic empty_flag;

   modport regs (
      output enable, auto_mode, gap_period, capacity, fill_ptr, cbr_idle, cell_done,
      input fetch_ptr, cell_req, empty_flag
   );
   modport xmit (
      input enable, auto_mode, gap_period, capacity, fill_ptr, cbr_idle, cell_done,
      output fetch_ptr, cell_req, empty_flag
   );
endinterface : cts_dtx_if

/* core/cts_data_tx.sv */
`timescale 1ns/100ps
`include "cts_defines.svh"

module cts_data_tx
   import cts_pkg::*;
#(
   parameter logic [15:0] GAP_UNIT_CLKS = `CTS_GAP_UNIT_CLKS
) (
   input wire logic clock_i,      // Master clock
   input wire logic sys_rst_i,    // Async reset, active high
   cts_dtx_if.xmit dtx            // Control in, pointer and request out
);

   cts_tx_state_t state, next_state;
   logic [6:0] rd, next_rd;
   logic req, next_req;
   logic empty, next_empty;
   logic [15:0] pre, next_pre;
   logic [9:0] units, next_units;
   logic [6:0] mask;
   logic [6:0] fill_m;
   logic pace_ok;

   // ****************************************
   // Scheduler next state
   // ****************************************
   always_comb begin
      mask = {dtx.capacity == 2'h3, dtx.capacity >= 2'h2, dtx.capacity != 2'h0, 4'hF};
      fill_m = dtx.fill_ptr[6:0] & mask;
      pace_ok = dtx.auto_mode ? dtx.cbr_idle :
                (dtx.gap_period != 10'h000) && (units >= dtx.gap_period);
      next_state = state;
      next_rd = rd;
      next_req = req;
      next_empty = empty;
      next_pre = pre;
      next_units = units;
      if (!dtx.enable) begin
         next_state = CTS_TX_IDLE;
         next_rd = 7'h00;
         next_req = 1'b0;
         next_empty = 1'b0;
         next_pre = 16'h0000;
         next_units = 10'h000;
      end else begin
         if (rd == fill_m) begin
            next_empty = 1'b1;
         end
         if (!dtx.auto_mode && (units < dtx.gap_period)) begin
            if (pre == GAP_UNIT_CLKS - 16'h0001) begin
               next_pre = 16'h0000;
               next_units = units + 10'h001;
            end else begin
               next_pre = pre + 16'h0001;
            end
         end
         unique case (state)
            CTS_TX_IDLE: begin
               // Slot under fill by the CPU is never sent
               if ((rd != fill_m) && pace_ok) begin
                  next_req = 1'b1;
                  next_state = CTS_TX_FETCH;
               end
            end
            CTS_TX_FETCH: begin
               if (dtx.cell_done) begin
                  next_req = 1'b0;
                  next_rd = (rd + 7'h01) & mask;
                  next_pre = 16'h0000;
                  next_units = 10'h000;
                  next_state = CTS_TX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= CTS_TX_IDLE;
         rd <= 7'h00;
         req <= 1'b0;
         empty <= 1'b0;
         pre <= 16'h0000;
         units <= 10'h000;
      end else begin
         state <= next_state;
         rd <= next_rd;
         req <= next_req;
         empty <= next_empty;
         pre <= next_pre;
         units <= next_units;
      end
   end

   assign dtx.fetch_ptr = rd;
   assign dtx.cell_req = req;
   assign dtx.empty_flag = empty;

endmodule : cts_data_tx

/* core/cts_tx_regs.sv */
`timescale 1ns/100ps
`include "cts_defines.svh"

// Overview of operation
// - Port bits 15:14 select off/unstructured/structured mode
// - Port bits 13:0 give table base word
// - Capacity field sets 16/32/64/128 cell buffer
// - Base field gives buffer word address 19:12
// - Slot under CPU fill is never sent
// - Read pointer shows slot being fetched
// - Disabled transmitter holds pointer zero, sends nothing
// - Enabled transmitter sends cells toward write pointer
// - Auto bit: send when segmenter idle
// - Empty service request gated by enable bit
// - Empty set on pointer match, cleared disabling
// - Gap spaces cells 65535 clocks times value
// - Master enable off stops all port cells

module cts_tx_regs
   import cts_pkg::*;
#(
   parameter logic [15:0] GAP_UNIT_CLKS = `CTS_GAP_UNIT_CLKS
) (
   input wire logic clock_i,                 // Master clock, 10 MHz
   input wire logic sys_rst_i,               // Async reset, active high
   input wire logic [15:0] cpu_addr_i,       // Register byte address
   input wire logic [15:0] cpu_wdata_i,      // Write data
   input wire logic cpu_wr_i,                // Write strobe, one cycle
   input wire logic cpu_rd_i,                // Read strobe, one cycle
   output logic [15:0] cpu_rdata_o,          // Read data, cycle after strobe
   input wire logic cbr_idle_i,              // Constant-rate segmenter idle
   input wire logic data_cell_done_i,        // Requested data cell sent
   output logic data_cell_req_o,             // Data cell request, held to done
   output logic [6:0] data_cell_slot_o,      // Slot being fetched
   output logic [7:0] buffer_base_upper_o,   // Buffer word address 19:12
   output logic empty_service_o,             // CPU service request
   output logic [55:0] port_mode_select_o,   // Effective mode, 2 bits per port
   output logic [391:0] port_table_base_o    // Table base, 14 bits per port
);

   // ****************************************
   // Register state
   // ****************************************
   logic [15:0] port_reg [`CTS_NUM_PORTS];
   logic [9:0] buf_config, next_buf_config;
   logic [7:0] buf_wptr, next_buf_wptr;
   logic [2:0] tx_ctrl, next_tx_ctrl;
   logic [9:0] gap_timer, next_gap_timer;
   logic master_en, next_master_en;
   logic [15:0] next_rdata;
   logic next_service;
   logic [55:0] next_port_mode;
   logic [391:0] next_port_base;
   logic [7:0] next_base_upper;

   cts_dtx_if dtx ();

   // ****************************************
   // Per-port pointer-base registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < `CTS_NUM_PORTS; g++) begin : g_port
         logic [15:0] next_port;
         always_comb begin
            next_port = port_reg[g];
            if (cpu_wr_i && (cpu_addr_i == `CTS_PORT_BASE_OFS + 16'(g) * `CTS_PORT_STRIDE)) begin
               next_port = cpu_wdata_i;
            end
         end
         always_ff @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               port_reg[g] <= `CTS_PORT_RST;
            end else begin
               port_reg[g] <= next_port;
            end
         end
      end
   endgenerate

   // ****************************************
   // Buffer and transmit control registers
   // ****************************************
   always_comb begin
      next_buf_config = buf_config;
      next_buf_wptr = buf_wptr;
      next_tx_ctrl = tx_ctrl;
      next_gap_timer = gap_timer;
      next_master_en = master_en;
      if (cpu_wr_i) begin
         unique case (cpu_addr_i)
            `CTS_BUF_CONFIG_OFS: next_buf_config = cpu_wdata_i[`CTS_BUF_BASE_MSB:0];
            `CTS_BUF_WPTR_OFS: next_buf_wptr = cpu_wdata_i[`CTS_FILL_PTR_MSB:0];
            `CTS_TX_CTRL_OFS: next_tx_ctrl = cpu_wdata_i[`CTS_EMPTY_SE_BIT:0];
            `CTS_GAP_TIMER_OFS: next_gap_timer = cpu_wdata_i[`CTS_GAP_MSB:0];
            `CTS_MASTER_EN_OFS: next_master_en = cpu_wdata_i[0];
            default: next_master_en = master_en;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         buf_config <= `CTS_BUF_CONFIG_RST;
         buf_wptr <= `CTS_BUF_WPTR_RST;
         tx_ctrl <= `CTS_TX_CTRL_RST;
         gap_timer <= `CTS_GAP_TIMER_RST;
         master_en <= `CTS_MASTER_EN_RST;
      end else begin
         buf_config <= next_buf_config;
         buf_wptr <= next_buf_wptr;
         tx_ctrl <= next_tx_ctrl;
         gap_timer <= next_gap_timer;
         master_en <= next_master_en;
      end
   end

   // ****************************************
   // Data transmitter
   // ****************************************
   assign dtx.enable = tx_ctrl[`CTS_EN_BIT];
   assign dtx.auto_mode = tx_ctrl[`CTS_AUTO_BIT];
   assign dtx.gap_period = gap_timer;
   assign dtx.capacity = buf_config[`CTS_CAPACITY_MSB:0];
   assign dtx.fill_ptr = buf_wptr;
   assign dtx.cbr_idle = cbr_idle_i;
   assign dtx.cell_done = data_cell_done_i;

   cts_data_tx #(
      .GAP_UNIT_CLKS(GAP_UNIT_CLKS)
   ) u_data_tx (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .dtx(dtx.xmit)
   );

   assign data_cell_req_o = dtx.cell_req;
   assign data_cell_slot_o = dtx.fetch_ptr;

   // ****************************************
   // Read path and registered outputs
   // ****************************************
   always_comb begin
      next_rdata = 16'h0000;
      if (cpu_rd_i) begin
         for (int p = 0; p < `CTS_NUM_PORTS; p++) begin
            if (cpu_addr_i == `CTS_PORT_BASE_OFS + 16'(p) * `CTS_PORT_STRIDE) begin
               next_rdata = port_reg[p];
            end
         end
         unique case (cpu_addr_i)
            `CTS_BUF_CONFIG_OFS: next_rdata = {6'h00, buf_config};
            `CTS_BUF_WPTR_OFS: next_rdata = {8'h00, buf_wptr};
            `CTS_BUF_RPTR_OFS: next_rdata = {9'h000, dtx.fetch_ptr};
            `CTS_TX_CTRL_OFS: next_rdata = {13'h0000, tx_ctrl};
            `CTS_GAP_TIMER_OFS: next_rdata = {6'h00, gap_timer};
            `CTS_TX_STATUS_OFS: next_rdata = {15'h0000, dtx.empty_flag};
            `CTS_MASTER_EN_OFS: next_rdata = {15'h0000, master_en};
            default: next_rdata = next_rdata;
         endcase
      end
      next_service = dtx.empty_flag & tx_ctrl[`CTS_EMPTY_SE_BIT];
      next_base_upper = buf_config[`CTS_BUF_BASE_MSB:`CTS_BUF_BASE_LSB];
      for (int p = 0; p < `CTS_NUM_PORTS; p++) begin
         // Reserved mode code and master disable give no cells
         if (master_en && (port_reg[p][15:`CTS_PORT_MODE_LSB] != CTS_MODE_RSVD)) begin
            next_port_mode[2*p +: 2] = port_reg[p][15:`CTS_PORT_MODE_LSB];
         end else begin
            next_port_mode[2*p +: 2] = CTS_MODE_OFF;
         end
         next_port_base[14*p +: 14] = port_reg[p][`CTS_PORT_BASE_MSB:0];
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cpu_rdata_o <= 16'h0000;
         empty_service_o <= 1'b0;
         buffer_base_upper_o <= 8'h00;
         port_mode_select_o <= 56'h0;
         port_table_base_o <= 392'h0;
      end else begin
         cpu_rdata_o <= next_rdata;
         empty_service_o <= next_service;
         buffer_base_upper_o <= next_base_upper;
         port_mode_select_o <= next_port_mode;
         port_table_base_o <= next_port_base;
      end
   end

endmodule : cts_tx_regs

/* dv/cts_tx_checker.sv */
`timescale 1ns/100ps
// ****************
// Port checks
// ****************
module cts_tx_checker (
   input wire logic clock_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic [15:0] cpu_addr_i, // Address
   input wire logic [15:0] cpu_wdata_i, // Write data
   input wire logic cpu_wr_i, // Write
   input wire logic cpu_rd_i, // Read
   input wire logic [15:0] cpu_rdata_o, // Read data
   input wire logic cbr_idle_i, // Idle
   input wire logic data_cell_done_i, // Done
   input wire logic data_cell_req_o, // Request
   input wire logic [6:0] data_cell_slot_o, // Slot
   input wire logic [7:0] buffer_base_upper_o, // Base
   input wire logic empty_service_o, // Service
   input wire logic [55:0] port_mode_select_o, // Modes
   input wire logic [391:0] port_table_base_o // Bases
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic ctl_wr;
   logic hand;
   assign ctl_wr = cpu_wr_i && cpu_addr_i == 16'h103E;
   assign hand = data_cell_req_o && data_cell_done_i;
   rdata_quiet_a: assert property (!cpu_rd_i |=> cpu_rdata_o == 16'h0000)
      else $error("read data not idle");
   ptr_read_a: assert property (cpu_rd_i && cpu_addr_i == 16'h103C
      |=> cpu_rdata_o == {9'h000, $past(data_cell_slot_o)}) else $error("pointer read wrong");
   cfg_rsvd_a: assert property (cpu_rd_i && cpu_addr_i == 16'h1038
      |=> cpu_rdata_o[15:10] == 6'h00) else $error("config spare bits set");
   req_hold_a: assert property (data_cell_req_o && !data_cell_done_i && !ctl_wr
      && !$past(ctl_wr) |=> data_cell_req_o) else $error("request dropped early");
   done_drop_a: assert property (hand |=> !data_cell_req_o)
      else $error("request held after done");
   slot_step_a: assert property (hand && !ctl_wr && !$past(ctl_wr)
      |=> data_cell_slot_o == $past(data_cell_slot_o) + 7'h01 || data_cell_slot_o == 7'h00)
      else $error("slot step wrong");
   slot_hold_a: assert property (!hand && !ctl_wr && !$past(ctl_wr)
      |=> $stable(data_cell_slot_o)) else $error("slot moved without done");
   tx_disable_a: assert property (ctl_wr && !cpu_wdata_i[0]
      |-> ##2 !data_cell_req_o && data_cell_slot_o == 7'h00) else $error("disable not seen");
   svc_off_a: assert property (ctl_wr && !cpu_wdata_i[0]
      |-> ##[2:3] !empty_service_o) else $error("service stays up");
   master_off_a: assert property (cpu_wr_i && cpu_addr_i == 16'h1044
      && !cpu_wdata_i[0] |-> ##[1:2] port_mode_select_o == 56'h0) else $error("modes not off");
endmodule : cts_tx_checker

bind cts_tx_regs cts_tx_checker u_cts_tx_checker (.clock_i, .sys_rst_i, .cpu_addr_i,
   .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i, .cpu_rdata_o, .cbr_idle_i, .data_cell_done_i,
   .data_cell_req_o, .data_cell_slot_o, .buffer_base_upper_o, .empty_service_o,
   .port_mode_select_o, .port_table_base_o);

/* dv/cts_cell_sink.sv */
`timescale 1ns/100ps
// ****************
// Cell taker model
// ****************
module cts_cell_sink (
   input wire logic clock_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic req_i, // Cell request
   input wire logic slow_i, // Answer late
   input wire logic busy_i, // Rate segmenter busy
   output logic cbr_idle_o, // Rate segmenter idle
   output logic done_o // Cell taken
);
   logic [2:0] wait_cnt;
   assign cbr_idle_o = !busy_i;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wait_cnt <= 3'h0;
         done_o <= 1'b0;
      end else begin
         done_o <= req_i && !done_o && wait_cnt >= (slow_i ? 3'h4 : 3'h0);
         wait_cnt <= (req_i && !done_o) ? wait_cnt + 3'h1 : 3'h0;
      end
   end
endmodule : cts_cell_sink

/* dv/cell_transmit_port_and_data_buffer_ctrl_test.sv */
`timescale 1ns/100ps
module cell_transmit_port_and_data_buffer_ctrl_test;
   import cts_pkg::*;
   logic clock_i = 0, sys_rst_i = 1, cpu_wr_i = 0, cpu_rd_i = 0, busy = 0, slow = 1;
   logic [15:0] cpu_addr_i = 16'h0000, cpu_wdata_i = 16'h0000, cpu_rdata_o, lfsr = 16'hCB98;
   logic idle, done, req, svc;
   logic [6:0] slot;
   logic [7:0] base;
   logic [55:0] modes;
   logic [391:0] tbase;
   int err_total = 0, cmp_count = 0, cells = 0, cyc = 0, c0;
   cts_tx_regs #(.GAP_UNIT_CLKS(16'h0004)) u_cts_tx_regs (.clock_i, .sys_rst_i, .cpu_addr_i,
      .cpu_wdata_i, .cpu_wr_i, .cpu_rd_i, .cpu_rdata_o, .cbr_idle_i(idle),
      .data_cell_done_i(done), .data_cell_req_o(req), .data_cell_slot_o(slot),
      .buffer_base_upper_o(base), .empty_service_o(svc), .port_mode_select_o(modes),
      .port_table_base_o(tbase));
   cts_cell_sink u_cts_cell_sink (.clock_i, .sys_rst_i, .req_i(req), .slow_i(slow),
      .busy_i(busy), .cbr_idle_o(idle), .done_o(done));
   // ****************
   // Helpers
   // ****************
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   function automatic logic [1:0] mode_exp(input logic [1:0] c);
      return (c == 2'h2) ? 2'h0 : c;
   endfunction : mode_exp
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock_i);
      cpu_wr_i <= 1'b1;
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      @(posedge clock_i);
      cpu_wr_i <= 1'b0;
   endtask : wr
   task automatic rc(input logic [15:0] a, input logic [15:0] e);
      @(posedge clock_i);
      cpu_rd_i <= 1'b1;
      cpu_addr_i <= a;
      @(posedge clock_i);
      cpu_rd_i <= 1'b0;
      @(negedge clock_i);
      chk(cpu_rdata_o, e);
   endtask : rc
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (done && req) begin
         cells <= cells + 1;
      end
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end
   initial forever #50 clock_i = ~clock_i;
   // ****************
   // Scenarios
   // ****************
   initial begin
      logic [15:0] d;
      int p;
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rc(16'h1000 + 16'(i * 2) * 16'h001B, 16'h0000);
      end
      rc(16'h1040, 16'h0001);
      wr(16'h1044, 16'h0001);
      for (int m = 0; m < 4; m++) begin
         p = (m == 3) ? 27 : lfsr % 28;
         lfsr = nxt(lfsr);
         d = {m[1:0], lfsr[13:0] & 14'h3FE0};
         lfsr = nxt(lfsr);
         wr(16'h1000 + 16'(p * 2), d);
         rc(16'h1000 + 16'(p * 2), d);
         chk(modes[2 * p +: 2], mode_exp(d[15:14]));
         chk(tbase[14 * p +: 14], d[13:0]);
      end
      wr(16'h1044, 16'h0000);
      repeat (3) @(negedge clock_i);
      chk(modes, 56'h0);
      d = lfsr;
      wr(16'h1038, d);
      rc(16'h1038, d & 16'h03FF);
      chk(base, d[9:2]);
      wr(16'h103C, 16'h007F);
      rc(16'h103C, 16'h0000);
      rc(16'h2000, 16'h0000);
      wr(16'h103A, 16'hFFFF);
      rc(16'h103A, 16'h00FF);
      wr(16'h1038, 16'h0000);
      wr(16'h103A, 16'h0003);
      wr(16'h103E, 16'h0007);
      for (int i = 0; i < 400 && svc !== 1'b1; i++) @(posedge clock_i);
      @(negedge clock_i);
      chk(slot, 7'h03);
      chk(cells, 3);
      chk(svc, 1'b1);
      rc(16'h1042, 16'h0001);
      busy <= 1'b1;
      slow <= 1'b0;
      wr(16'h103A, 16'h0011);
      repeat (30) @(posedge clock_i);
      chk(cells, 3);
      busy <= 1'b0;
      for (int i = 0; i < 800 && slot !== 7'h01; i++) @(posedge clock_i);
      repeat (10) @(negedge clock_i);
      chk(cells, 17);
      wr(16'h103A, 16'h0009);
      repeat (6) @(posedge clock_i);
      wr(16'h103E, 16'h0000);
      repeat (3) @(negedge clock_i);
      chk({req, svc, slot}, 9'h000);
      rc(16'h103C, 16'h0000);
      rc(16'h1042, 16'h0000);
      wr(16'h1040, 16'h0000);
      wr(16'h103E, 16'h0001);
      c0 = cells;
      repeat (60) @(posedge clock_i);
      chk(cells - c0, 0);
      wr(16'h1040, 16'h0002);
      c0 = cells;
      repeat (100) @(negedge clock_i);
      chk((cells - c0) inside {[1:12]}, 1'b1);
      test_done();
   end
endmodule : cell_transmit_port_and_data_buffer_ctrl_test
